// [partition_label_propagation_tb.sv]
/*
  Self-checking bench: requester and component joined by the link,
  with a bench downstream memory that stalls at random.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
      n_fail++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module partition_label_propagation_tb;
  logic ref_clk = 0, reset_n = 0, usr_valid = 0, usr_write = 0;
  logic usr_ready, label_gen_enable = 0, secure_state = 0;
  logic terminate_mode = 0, usr_resp_valid, ds_valid, ds_write;
  logic ds_ready = 0, ds_resp_valid = 0;
  logic [11:0] usr_addr = 0, ds_addr, cur_addr = 0;
  logic [31:0] usr_wdata = 0, usr_resp_rdata, ds_wdata;
  logic [31:0] ds_resp_rdata = 0, seed = 32'h6921e71e, r;
  logic [15:0] per_level_label_partition = 0, processor_label_ident_reg;
  logic [15:0] component_ident_reg, component_secure_ident_reg;
  logic [15:0] ctl_partition;
  logic [7:0] per_level_label_mg = 0;
  plp_pkg::plp_label_t ds_label, exp_lbl;
  logic cur_w = 0, fwd_seen = 0;
  logic [31:0] cur_wdata = 0;
  logic [24:0] line_lbl;
  logic [31:0] ds_mem [4096];
  logic [31:0] lmem [16];
  int n_fail = 0, cmp_count = 0, dly;

  always #50 ref_clk = ~ref_clk;

  plp_link_if plp_link_if_inst (.ref_clk(ref_clk));
  plp_requester plp_requester_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .link(plp_link_if_inst), .usr_valid(usr_valid), .usr_ready(usr_ready),
    .usr_write(usr_write), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
    .label_gen_enable(label_gen_enable), .secure_state(secure_state),
    .per_level_label_partition(per_level_label_partition),
    .per_level_label_mg(per_level_label_mg),
    .processor_label_ident_reg(processor_label_ident_reg),
    .usr_resp_valid(usr_resp_valid), .usr_resp_rdata(usr_resp_rdata));
  plp_component plp_component_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .link(plp_link_if_inst), .terminate_mode(terminate_mode),
    .component_ident_reg(component_ident_reg),
    .component_secure_ident_reg(component_secure_ident_reg),
    .ctl_partition(ctl_partition), .ds_valid(ds_valid),
    .ds_ready(ds_ready), .ds_write(ds_write), .ds_addr(ds_addr),
    .ds_wdata(ds_wdata), .ds_label(ds_label),
    .ds_resp_valid(ds_resp_valid), .ds_resp_rdata(ds_resp_rdata));
  plp_link_props plp_props_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .req_valid(plp_link_if_inst.req_valid),
    .req_ready(plp_link_if_inst.req_ready),
    .req_write(plp_link_if_inst.req_write),
    .req_addr(plp_link_if_inst.req_addr),
    .req_wdata(plp_link_if_inst.req_wdata),
    .req_label(plp_link_if_inst.req_label),
    .resp_valid(plp_link_if_inst.resp_valid),
    .resp_rdata(plp_link_if_inst.resp_rdata));

  // Label recorded with the cache line of the current address
  assign line_lbl = plp_component_inst.r_q.c_label[cur_addr[1:0]];

  // Repeatable xorshift source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Label expected on the wire for given software settings
  function automatic plp_pkg::plp_label_t exp_label(logic en, logic sec,
      logic [15:0] part, logic [7:0] mg);
    plp_pkg::plp_label_t l;
    l = '{16'h0000, 8'h00, sec};
    if (en && part <= plp_pkg::REQ_MAX_PARTITION) begin
      l.partition_id = part;
      l.monitor_group = (mg <= plp_pkg::REQ_MAX_MG) ? mg : 8'h00;
    end
    return l;
  endfunction

  // Control identifier after the space maximum check
  function automatic logic [15:0] exp_ctl(plp_pkg::plp_label_t l);
    logic [15:0] mx;
    mx = l.label_secure_space_bit ? 16'h000f : 16'h003f;
    return (l.partition_id > mx) ? 16'h0000 : l.partition_id;
  endfunction

  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One user request, waits for its answer and checks it
  task automatic do_req(logic w, logic [11:0] a, logic [31:0] d, logic en,
      logic sec, logic [15:0] part, logic [7:0] mg);
    int k;
    logic [31:0] exp_rd;
    exp_lbl = exp_label(en, sec, part, mg);
    {cur_addr, cur_w, cur_wdata, fwd_seen} = {a, w, d, 1'b0};
    k = 0;
    while (usr_ready !== 1'b1 && k < 50) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    `CHK("usr_ready", 1'b1, usr_ready)
    {usr_valid, usr_write, usr_addr, usr_wdata} = {1'b1, w, a, d};
    {label_gen_enable, secure_state} = {en, sec};
    {per_level_label_partition, per_level_label_mg} = {part, mg};
    @(posedge ref_clk);
    #1;
    usr_valid = 0;
    k = 0;
    while (usr_resp_valid !== 1'b1 && k < 60) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    `CHK("usr_resp_valid", 1'b1, usr_resp_valid)
    if (!w) begin
      exp_rd = terminate_mode ? lmem[a[3:0]] : ds_mem[a];
      `CHK("rdata", exp_rd, usr_resp_rdata)
    end else if (terminate_mode) begin
      lmem[a[3:0]] = d;
    end
    if (!w && !terminate_mode && fwd_seen)
      `CHK("line label", exp_lbl, line_lbl)
    `CHK("ctl_partition", exp_ctl(exp_lbl), ctl_partition)
  endtask

  // Downstream memory with random stalls
  always begin
    @(posedge ref_clk);
    #1;
    if (ds_valid === 1'b1) begin
      fwd_seen = 1;
      `CHK("ds_label", exp_lbl, ds_label)
      `CHK("ds_addr", cur_addr, ds_addr)
      `CHK("ds_write", cur_w, ds_write)
      `CHK("ds_wdata", cur_wdata, ds_wdata)
      `CHK("forward in terminate", 1'b0, terminate_mode)
      dly = int'(xs() % 4);
      repeat (dly) begin
        @(posedge ref_clk);
        #1;
      end
      ds_ready = 1;
      @(posedge ref_clk);
      #1 ds_ready = 0;
      if (ds_write) ds_mem[ds_addr] = ds_wdata;
      repeat (dly) begin
        @(posedge ref_clk);
        #1;
      end
      ds_resp_rdata = ds_mem[ds_addr];
      ds_resp_valid = 1;
      @(posedge ref_clk);
      #1 ds_resp_valid = 0;
      ds_resp_rdata = ~ds_resp_rdata; // Released data is not held
    end
  end

  // Main sequence
  initial begin
    for (int i = 0; i < 4096; i++) ds_mem[i] = 32'h5a000000 + i;
    for (int i = 0; i < 16; i++) lmem[i] = 32'h00000000;
    repeat (4) @(posedge ref_clk);
    #1 reset_n = 1;
    `CHK("proc ident", 16'h00ff, processor_label_ident_reg)
    `CHK("comp ident", 16'h003f, component_ident_reg)
    `CHK("comp s ident", 16'h000f, component_secure_ident_reg)
    do_req(0, 12'h004, 0, 0, 1, 16'h0005, 8'h03);
    do_req(1, 12'h004, 32'h1234abcd, 1, 0, 16'h00ff, 8'h0f);
    do_req(0, 12'h004, 0, 1, 1, 16'h0100, 8'h02);
    `CHK("hit kept local", 1'b0, fwd_seen)
    do_req(0, 12'h008, 0, 1, 0, 16'h0010, 8'h10);
    do_req(0, 12'h008, 0, 1, 1, 16'h0010, 8'h01);
    for (int i = 0; i < 80; i++) begin
      r = xs();
      terminate_mode = (i >= 40 && i < 60);
      do_req(r[0], {6'h00, r[6:1]}, xs(), r[7] | r[8], r[9],
             r[10] ? {8'h00, r[23:16]} : r[31:16], r[15:8]);
    end
    final_report();
  end

  // Watchdog
  initial begin
    #3000000;
    n_fail++;
    final_report();
  end
endmodule

// [plp_component.sv]
/*
  Memory-system component end: takes labelled requests from the link,
  holds them in a request buffer, serves them from a small cache or a
  local store, and outside terminate mode forwards misses and writes downstream with the
  label untouched. Assumes the downstream slave answers each forwarded
  request with one response pulse and that the requester waits for the
  answer before issuing again.
*/
`timescale 1ns/1ps
module plp_component (
  input wire logic ref_clk,
  input wire logic reset_n,
  plp_link_if.component link,
  input wire logic terminate_mode,
  output logic [plp_pkg::PART_W-1:0] component_ident_reg,
  output logic [plp_pkg::PART_W-1:0] component_secure_ident_reg,
  output logic [plp_pkg::PART_W-1:0] ctl_partition,
  output logic ds_valid,
  input wire logic ds_ready,
  output logic ds_write,
  output logic [plp_pkg::ADDR_W-1:0] ds_addr,
  output logic [plp_pkg::DATA_W-1:0] ds_wdata,
  output plp_pkg::plp_label_t ds_label,
  input wire logic ds_resp_valid,
  input wire logic [plp_pkg::DATA_W-1:0] ds_resp_rdata
);

  typedef enum {
    PLP_CO_IDLE,
    PLP_CO_LOOKUP,
    PLP_CO_FWD,
    PLP_CO_WAIT
  } plp_co_state_t;

  typedef struct packed {
    plp_co_state_t state;
    logic h_write;
    logic [plp_pkg::ADDR_W-1:0] h_addr;
    logic [plp_pkg::DATA_W-1:0] h_wdata;
    plp_pkg::plp_label_t h_label;
    logic [plp_pkg::PART_W-1:0] ctl_part;
    logic resp_valid;
    logic [plp_pkg::DATA_W-1:0] rdata;
    logic [plp_pkg::CACHE_LINES-1:0] c_valid;
    logic [plp_pkg::CACHE_LINES-1:0][plp_pkg::TAG_W-1:0] c_tag;
    logic [plp_pkg::CACHE_LINES-1:0][plp_pkg::DATA_W-1:0] c_data;
    logic [plp_pkg::CACHE_LINES-1:0][$bits(plp_pkg::plp_label_t)-1:0]
      c_label;
    logic [plp_pkg::LMEM_WORDS-1:0][plp_pkg::DATA_W-1:0] lmem;
  } plp_co_regs_t;

  plp_co_regs_t r_q;
  plp_co_regs_t r_d;
  logic [plp_pkg::IDX_W-1:0] idx;
  logic [plp_pkg::TAG_W-1:0] tag;
  logic [plp_pkg::LMEM_W-1:0] lidx;
  logic hit;
  logic [plp_pkg::PART_W-1:0] space_max;

  // ----------------------------------------------------------------
  // Address split and hit check
  // ----------------------------------------------------------------
  // Hit depends only on address, never on the label
  always_comb begin
    idx = r_q.h_addr[plp_pkg::IDX_W-1:0];
    tag = r_q.h_addr[plp_pkg::ADDR_W-1:plp_pkg::IDX_W];
    lidx = r_q.h_addr[plp_pkg::LMEM_W-1:0];
    hit = r_q.c_valid[idx] && (r_q.c_tag[idx] == tag);
    // Space maximum picked by the incoming secure bit
    if (link.req_label.label_secure_space_bit) begin
      space_max = plp_pkg::COMP_MAX_S_PARTITION;
    end else begin
      space_max = plp_pkg::COMP_MAX_NS_PARTITION;
    end
  end

  // ----------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------
  // Accept, serve locally, or forward downstream
  always_comb begin
    r_d = r_q;
    r_d.resp_valid = 1'b0;
    case (r_q.state)
      PLP_CO_IDLE: begin
        if (link.req_valid) begin
          r_d.h_write = link.req_write;
          r_d.h_addr = link.req_addr;
          r_d.h_wdata = link.req_wdata;
          r_d.h_label = link.req_label;
          r_d.ctl_part = plp_pkg::clamp_partition(
            link.req_label.partition_id, space_max);
          r_d.state = PLP_CO_LOOKUP;
        end
      end
      PLP_CO_LOOKUP: begin
        if (terminate_mode) begin
          // Terminating slave: serve from local store only
          if (r_q.h_write) begin
            r_d.lmem[lidx] = r_q.h_wdata;
          end else begin
            r_d.rdata = r_q.lmem[lidx];
          end
          r_d.resp_valid = 1'b1;
          r_d.state = PLP_CO_IDLE;
        end else if (!r_q.h_write && hit) begin
          // Read hit served here, nothing goes downstream
          r_d.rdata = r_q.c_data[idx];
          r_d.resp_valid = 1'b1;
          r_d.state = PLP_CO_IDLE;
        end else begin
          // Write-through keeps the allocating label on the line
          if (r_q.h_write && hit) begin
            r_d.c_data[idx] = r_q.h_wdata;
          end
          r_d.state = PLP_CO_FWD;
        end
      end
      PLP_CO_FWD: begin
        // Request and label stay put until the slave takes them
        if (ds_ready) begin
          r_d.state = PLP_CO_WAIT;
        end
      end
      PLP_CO_WAIT: begin
        if (ds_resp_valid) begin
          // Read misses allocate, tagging the line with its label
          if (!r_q.h_write) begin
            r_d.c_valid[idx] = 1'b1;
            r_d.c_tag[idx] = tag;
            r_d.c_data[idx] = ds_resp_rdata;
            r_d.c_label[idx] = r_q.h_label;
            r_d.rdata = ds_resp_rdata;
          end
          r_d.resp_valid = 1'b1;
          r_d.state = PLP_CO_IDLE;
        end
      end
      default: begin
        r_d.state = PLP_CO_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_q.state <= PLP_CO_IDLE;
      r_q.h_write <= 1'b0;
      r_q.h_addr <= '0;
      r_q.h_wdata <= '0;
      r_q.h_label <= plp_pkg::LABEL_RESET;
      r_q.ctl_part <= plp_pkg::DEFAULT_PARTITION;
      r_q.resp_valid <= 1'b0;
      r_q.rdata <= '0;
      r_q.c_valid <= '0;
      r_q.c_tag <= '0;
      r_q.c_data <= '0;
      r_q.c_label <= '0;
      r_q.lmem <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Link answers and identification values
  assign link.req_ready = (r_q.state == PLP_CO_IDLE);
  assign link.resp_valid = r_q.resp_valid;
  assign link.resp_rdata = r_q.rdata;
  assign component_ident_reg = plp_pkg::COMP_MAX_NS_PARTITION;
  assign component_secure_ident_reg = plp_pkg::COMP_MAX_S_PARTITION;
  assign ctl_partition = r_q.ctl_part;

  // Downstream port; label passes unaltered from the buffer
  assign ds_valid = (r_q.state == PLP_CO_FWD);
  assign ds_write = r_q.h_write;
  assign ds_addr = r_q.h_addr;
  assign ds_wdata = r_q.h_wdata;
  assign ds_label = r_q.h_label;

endmodule

// [plp_link_if.sv]
/*
  Request link between a labelling requester and a memory-system
  component. Assumes one shared clock; no clocking block.
*/
`timescale 1ns/1ps
interface plp_link_if (
  input wire logic ref_clk
);

  // ----------------------------------------------------------------
  // Request and response signals
  // ----------------------------------------------------------------
  logic req_valid;
  logic req_ready;
  logic req_write;
  logic [plp_pkg::ADDR_W-1:0] req_addr;
  logic [plp_pkg::DATA_W-1:0] req_wdata;
  plp_pkg::plp_label_t req_label;
  logic resp_valid;
  logic [plp_pkg::DATA_W-1:0] resp_rdata;

  modport requester (
    output req_valid,
    input req_ready,
    output req_write,
    output req_addr,
    output req_wdata,
    output req_label,
    input resp_valid,
    input resp_rdata
  );

  modport component (
    input req_valid,
    output req_ready,
    input req_write,
    input req_addr,
    input req_wdata,
    input req_label,
    output resp_valid,
    output resp_rdata
  );

endinterface

// [plp_link_props.sv]
/*
  Checker for the partition label link between requester and component.
  Assumes it is instantiated beside the link interface in the bench.
*/
`timescale 1ns/1ps
module plp_link_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic req_write,
  input wire logic [plp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [plp_pkg::DATA_W-1:0] req_wdata,
  input wire plp_pkg::plp_label_t req_label,
  input wire logic resp_valid,
  input wire logic [plp_pkg::DATA_W-1:0] resp_rdata
);
  // ----------------------------------------------------------------
  // Link properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_label_held: assert property (
    !req_ready |-> $stable(req_label) && $stable(req_addr))
    else $error("Label or address moved while busy");
  a_valid_once: assert property (
    req_valid && req_ready |=> !req_valid)
    else $error("Request still raised after take");
  a_take_busy: assert property (
    req_valid && req_ready |=> !req_ready)
    else $error("Ready stayed high after take");
  a_resp_pulse: assert property (
    resp_valid |=> !resp_valid)
    else $error("Response longer than one cycle");
  a_resp_bound: assert property (
    req_valid && req_ready |-> ##1 !resp_valid ##[1:40] resp_valid)
    else $error("Response missing or early");
  a_resp_idle: assert property (
    resp_valid |-> req_ready && !$past(req_ready))
    else $error("Ready wrong around response");
  a_part_range: assert property (
    req_valid |-> req_label.partition_id <= plp_pkg::REQ_MAX_PARTITION)
    else $error("Partition above requester maximum");
  a_group_range: assert property (
    req_valid |-> req_label.monitor_group <= plp_pkg::REQ_MAX_MG)
    else $error("Monitor group above requester maximum");

  // Main scenarios reached
  c_take: cover property (req_valid && req_ready);
  c_secure: cover property (req_valid && req_label.label_secure_space_bit);
  c_write: cover property (req_valid && req_ready && req_write);
endmodule

// [plp_pkg.sv]
/*
  Shared constants, label type and helper function for the partition
  label link between a requesting master and a memory-system component.
  Assumes both ends run on one 10 MHz clock with a synchronous reset.
*/
package plp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PART_W = 16;
  localparam int unsigned MG_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Default label values
  // ----------------------------------------------------------------
  localparam logic [PART_W-1:0] DEFAULT_PARTITION = 16'h0000;
  localparam logic [MG_W-1:0] DEFAULT_MG = 8'h00;

  // ----------------------------------------------------------------
  // Implementation maxima
  // ----------------------------------------------------------------
  localparam logic [PART_W-1:0] REQ_MAX_PARTITION = 16'h00ff;
  localparam logic [MG_W-1:0] REQ_MAX_MG = 8'h0f;
  localparam logic [PART_W-1:0] COMP_MAX_NS_PARTITION = 16'h003f;
  localparam logic [PART_W-1:0] COMP_MAX_S_PARTITION = 16'h000f;

  // ----------------------------------------------------------------
  // Component storage geometry
  // ----------------------------------------------------------------
  localparam int unsigned CACHE_LINES = 4;
  localparam int unsigned IDX_W = 2;
  localparam int unsigned TAG_W = ADDR_W - IDX_W;
  localparam int unsigned LMEM_WORDS = 16;
  localparam int unsigned LMEM_W = 4;

  // Label bundle carried with every request
  typedef struct packed {
    logic [PART_W-1:0] partition_id;
    logic [MG_W-1:0] monitor_group;
    logic label_secure_space_bit;
  } plp_label_t;

  localparam plp_label_t LABEL_RESET = '{DEFAULT_PARTITION, DEFAULT_MG,
                                         1'b0};

  // Out-of-range identifiers fall back to the default identifier
  function automatic logic [PART_W-1:0] clamp_partition(
    input logic [PART_W-1:0] id,
    input logic [PART_W-1:0] max_id
  );
    clamp_partition = (id > max_id) ? DEFAULT_PARTITION : id;
  endfunction

endpackage

// [plp_requester.sv]
/*
  Requesting master end: generates the label bundle for each user
  request and issues it on the link. Assumes the component answers
  every request with one response pulse.
*/
`timescale 1ns/1ps
module plp_requester (
  input wire logic ref_clk,
  input wire logic reset_n,
  plp_link_if.requester link,
  input wire logic usr_valid,
  output logic usr_ready,
  input wire logic usr_write,
  input wire logic [plp_pkg::ADDR_W-1:0] usr_addr,
  input wire logic [plp_pkg::DATA_W-1:0] usr_wdata,
  input wire logic label_gen_enable,
  input wire logic secure_state,
  input wire logic [plp_pkg::PART_W-1:0] per_level_label_partition,
  input wire logic [plp_pkg::MG_W-1:0] per_level_label_mg,
  output logic [plp_pkg::PART_W-1:0] processor_label_ident_reg,
  output logic usr_resp_valid,
  output logic [plp_pkg::DATA_W-1:0] usr_resp_rdata
);

  typedef enum {
    PLP_RQ_IDLE,
    PLP_RQ_ISSUE,
    PLP_RQ_WAIT
  } plp_rq_state_t;

  typedef struct packed {
    plp_rq_state_t state;
    logic write;
    logic [plp_pkg::ADDR_W-1:0] addr;
    logic [plp_pkg::DATA_W-1:0] wdata;
    plp_pkg::plp_label_t label;
    logic resp_valid;
    logic [plp_pkg::DATA_W-1:0] rdata;
  } plp_rq_regs_t;

  plp_rq_regs_t r_q;
  plp_rq_regs_t r_d;
  plp_pkg::plp_label_t gen_label;
  logic part_err;
  logic mg_err;

  // ----------------------------------------------------------------
  // Label generation
  // ----------------------------------------------------------------
  // Errors fall back to defaults; secure bit follows security state
  always_comb begin
    part_err = per_level_label_partition > plp_pkg::REQ_MAX_PARTITION;
    mg_err = per_level_label_mg > plp_pkg::REQ_MAX_MG;
    gen_label.label_secure_space_bit = secure_state;
    if (!label_gen_enable) begin
      gen_label.partition_id = plp_pkg::DEFAULT_PARTITION;
      gen_label.monitor_group = plp_pkg::DEFAULT_MG;
    end else begin
      gen_label.partition_id = plp_pkg::clamp_partition(
        per_level_label_partition, plp_pkg::REQ_MAX_PARTITION);
      if (part_err || mg_err) begin
        gen_label.monitor_group = plp_pkg::DEFAULT_MG;
      end else begin
        gen_label.monitor_group = per_level_label_mg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request sequencing
  // ----------------------------------------------------------------
  // Next-state logic for the issuing master
  always_comb begin
    r_d = r_q;
    r_d.resp_valid = 1'b0;
    case (r_q.state)
      PLP_RQ_IDLE: begin
        if (usr_valid) begin
          r_d.write = usr_write;
          r_d.addr = usr_addr;
          r_d.wdata = usr_wdata;
          r_d.label = gen_label;
          r_d.state = PLP_RQ_ISSUE;
        end
      end
      PLP_RQ_ISSUE: begin
        if (link.req_ready) begin
          r_d.state = PLP_RQ_WAIT;
        end
      end
      PLP_RQ_WAIT: begin
        if (link.resp_valid) begin
          r_d.resp_valid = 1'b1;
          r_d.rdata = link.resp_rdata;
          r_d.state = PLP_RQ_IDLE;
        end
      end
      default: begin
        r_d.state = PLP_RQ_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      r_q <= '{PLP_RQ_IDLE, 1'b0, '0, '0, plp_pkg::LABEL_RESET, 1'b0, '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Link drive and user answers
  assign usr_ready = (r_q.state == PLP_RQ_IDLE);
  assign link.req_valid = (r_q.state == PLP_RQ_ISSUE);
  assign link.req_write = r_q.write;
  assign link.req_addr = r_q.addr;
  assign link.req_wdata = r_q.wdata;
  assign link.req_label = r_q.label;
  assign usr_resp_valid = r_q.resp_valid;
  assign usr_resp_rdata = r_q.rdata;
  assign processor_label_ident_reg = plp_pkg::REQ_MAX_PARTITION;

endmodule
